// *** rtl/fast_autoboot_loader.sv ***
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "boot_loader_map.svh"

module fast_autoboot_loader (
   // Clock and reset.
   input  wire logic                          clk,
   input  wire logic                          rst,
   // APB slave.
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [7:0]                    paddr,
   input  wire logic [31:0]                   pwdata,
   output      logic [31:0]                   prdata,
   output      logic                          pready,
   output      logic                          pslverr,
   // Interrupt to the system.
   output      logic                          irq,
   // Shared autoboot select and interrupt request pin.
   input  wire logic                          hostInterruptRequestNIn,
   output      logic                          hostInterruptRequestNOut,
   output      logic                          hostInterruptRequestNOe,
   // Serial download path.
   input  wire boot_loader_pkg::host_load_type hostLoad,
   input  wire logic                          imageCompatible,
   // External memory port.
   output      logic                          extMemOutputStrobeN,
   output      logic                          extMemSelectN,
   input  wire logic [7:0]                    extMemAddrDataIn,
   output      logic [7:0]                    extMemAddrDataOut,
   output      logic                          extMemAddrDataOe,
   // Fetched image bytes and boot state.
   output      logic                          fetchValid,
   output      logic [7:0]                    fetchByte,
   output      logic [3:0]                    divFactor,
   output      logic                          pllLocked,
   output      logic                          internalRomEnable,
   output      logic                          appRunning
);
   import boot_loader_pkg::*;

   localparam loader_state_type RESET_STATE = '{
      boot:         BOOT_IDLE,
      phase:        PH_ADDR_LOW,
      addrIdx:      2'h0,
      addr:         24'h000000,
      divFactor:    `DIV_STANDARD,
      divLoad:      1'b0,
      pllLocked:    1'b0,
      internalRom:  1'b0,
      appRunning:   1'b0,
      appFailed:    1'b0,
      reply:        8'h00,
      irqPinActive: 1'b0,
      irqStatus:    3'h0,
      irqMask:      3'h0,
      imageLen:     `IMAGE_LEN_RESET,
      kindInternal: 1'b0,
      prdata:       32'h00000000,
      strobeN:      1'b1,
      selectN:      1'b1,
      adOut:        8'h00,
      adOe:         1'b0,
      fetchValid:   1'b0,
      fetchByte:    8'h00,
      strapCnt:     2'h0,
      strapDone:    1'b0
   };

   // Registered state, its next value and the glue between them.
   loader_state_type s;
   loader_state_type next_s;
   logic             coreTick;
   logic [8:0]       pinsSynced;
   logic             wrAccess;
   logic             rdAccess;
   logic             setupRead;

   // True for every offset that holds a register.
   function automatic logic isMapped(input logic [7:0] addr);
      case (addr)
         `REG_CTRL, `REG_STATUS, `REG_REPLY,
         `REG_IRQ_STATUS, `REG_IRQ_MASK, `REG_IMAGE_LEN: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction : isMapped

   // Divide factor carried by each fast loader kind.
   function automatic logic [3:0] fastFactor(input load_kind_type kind);
      case (kind)
         LOAD_FAST8: fastFactor = `DIV_FAST8;
         LOAD_FAST6: fastFactor = `DIV_FAST6;
         LOAD_FAST4: fastFactor = `DIV_FAST4;
         default:    fastFactor = `DIV_STANDARD;
      endcase
   endfunction : fastFactor

   // The memory data bus and the shared pin come from outside the clock.
   pin_sync #(
      .WIDTH (9),
      .INIT  (9'h1ff)
   ) u_pin_sync (
      .clk    (clk),
      .rst    (rst),
      .pinIn  ({hostInterruptRequestNIn, extMemAddrDataIn}),
      .pinOut (pinsSynced)
   );

   // The core tick paces every external memory cycle.
   core_clock_divider u_divider (
      .clk     (clk),
      .rst     (rst),
      .factor  (s.divFactor),
      .restart (s.divLoad),
      .tick    (coreTick)
   );

   // Bus phases; the slave never waits.
   assign wrAccess  = psel && penable && pwrite && isMapped(paddr);
   assign rdAccess  = psel && penable && !pwrite && isMapped(paddr);
   assign setupRead = psel && !penable && !pwrite;

   // Next state: register effects, read data, then the boot sequence.
   always_comb begin
      logic [2:0] irqSet;
      logic [2:0] irqClr;
      logic       ackPulse;
      irqSet   = 3'h0;
      irqClr   = 3'h0;
      ackPulse = 1'b0;
      next_s   = s;
      next_s.divLoad    = 1'b0;
      next_s.fetchValid = 1'b0;

      // Register writes.
      if (wrAccess) begin
         case (paddr)
            `REG_CTRL: begin
               // Only this command locks the loop; loaders never do. [R4] [R5]
               if (pwdata[`CTRL_LOCK_BIT] && !s.pllLocked) begin
                  next_s.pllLocked = 1'b1;
                  irqSet[`IRQ_LOCK_BIT] = 1'b1;
               end
               ackPulse = pwdata[`CTRL_ACK_BIT];
               next_s.kindInternal = pwdata[`CTRL_KIND_BIT];
            end
            `REG_IRQ_STATUS: irqClr = pwdata[2:0];
            `REG_IRQ_MASK:   next_s.irqMask = pwdata[2:0];
            `REG_IMAGE_LEN:  next_s.imageLen = pwdata[15:0];
            default: ;
         endcase
      end

      // Collecting the pending byte releases the request line. [R11]
      if (rdAccess && paddr == `REG_REPLY) begin
         next_s.irqPinActive = 1'b0;
      end

      // Read data is prepared in the setup phase for a zero-wait access.
      if (setupRead) begin
         case (paddr)
            `REG_CTRL:       next_s.prdata = {29'h0, s.kindInternal, 2'h0};
            `REG_STATUS:     next_s.prdata = {20'h0, s.divFactor, 2'h0,
                                  s.boot == BOOT_HALT,
                                  s.boot == BOOT_FETCH, s.appFailed,
                                  s.appRunning, s.internalRom, s.pllLocked};
            `REG_REPLY:      next_s.prdata = {24'h0, s.reply};
            `REG_IRQ_STATUS: next_s.prdata = {29'h0, s.irqStatus};
            `REG_IRQ_MASK:   next_s.prdata = {29'h0, s.irqMask};
            `REG_IMAGE_LEN:  next_s.prdata = {16'h0, s.imageLen};
            default:         next_s.prdata = 32'h00000000;
         endcase
      end

      // Boot sequence.
      case (s.boot)
         BOOT_IDLE: begin
            if (!s.strapDone) begin
               // The strap is taken once the synchroniser has settled.
               next_s.strapCnt = s.strapCnt + 2'h1;
               if (s.strapCnt == `STRAP_SETTLE) begin
                  next_s.strapDone = 1'b1;
                  if (!pinsSynced[8]) begin
                     next_s.divFactor = `DIV_STANDARD; // [R3]
                     next_s.divLoad   = 1'b1;
                     next_s.boot      = BOOT_SETTLE;
                  end
               end
            end else if (hostLoad.done) begin
               // A host download arrives with the select line held high. [R1]
               irqSet[`IRQ_LOAD_BIT] = 1'b1;
               if (!hostLoad.checksumOk) begin
                  next_s.reply = `MSG_BAD_CHECKSUM;
                  next_s.boot  = BOOT_HALT;
               end else begin
                  next_s.reply = `MSG_DOWNLOAD_OK; // [R9]
                  case (hostLoad.kind)
                     LOAD_FAST8, LOAD_FAST6, LOAD_FAST4: begin
                        // Speed up first, then fetch like a pin autoboot.
                        next_s.divFactor = fastFactor(hostLoad.kind); // [R3]
                        next_s.divLoad   = 1'b1; // [R2]
                        next_s.boot      = BOOT_SETTLE;
                     end
                     LOAD_INTERNAL: begin
                        next_s.internalRom = 1'b1; // [R7] [R8]
                        next_s.boot        = BOOT_APP_WAIT;
                     end
                     default: next_s.boot = BOOT_APP_WAIT;
                  endcase
               end
            end
         end

         BOOT_SETTLE: begin
            // The first tick after the restart already runs at the new rate,
            // so all address cycles of the image share one period. [R16]
            if (coreTick) begin
               next_s.addr    = 24'h000000;
               next_s.addrIdx = 2'h0;
               next_s.phase   = PH_ADDR_LOW;
               next_s.boot    = BOOT_FETCH;
            end
         end

         BOOT_FETCH: begin
            if (coreTick) begin
               case (s.phase)
                  PH_ADDR_LOW: begin
                     // The most significant byte goes out first.
                     next_s.adOe    = 1'b1;
                     next_s.strobeN = 1'b0;
                     case (s.addrIdx)
                        2'h0:    next_s.adOut = s.addr[23:16];
                        2'h1:    next_s.adOut = s.addr[15:8];
                        default: next_s.adOut = s.addr[7:0];
                     endcase
                     next_s.phase = PH_ADDR_HIGH;
                  end
                  PH_ADDR_HIGH: begin
                     // This rising edge clocks the byte into a latch. [R14]
                     next_s.strobeN = 1'b1;
                     if (s.addrIdx == `ADDR_LAST_INDEX) begin
                        next_s.phase = PH_DATA_LOW;
                     end else begin
                        next_s.addrIdx = s.addrIdx + 2'h1;
                        next_s.phase   = PH_ADDR_LOW;
                     end
                  end
                  PH_DATA_LOW: begin
                     // Fourth low pulse with select low opens the memory.
                     next_s.adOe    = 1'b0; // [R14]
                     next_s.selectN = 1'b0;
                     next_s.strobeN = 1'b0;
                     next_s.phase   = PH_DATA_HIGH;
                  end
                  PH_DATA_HIGH: begin
                     // Data is taken after a full core period, which covers
                     // the two-cycle delay of the pin synchroniser.
                     next_s.fetchByte  = pinsSynced[7:0];
                     next_s.fetchValid = 1'b1;
                     next_s.strobeN    = 1'b1;
                     next_s.selectN    = 1'b1;
                     next_s.addr       = s.addr + 24'h000001;
                     next_s.addrIdx    = 2'h0;
                     next_s.phase      = PH_ADDR_LOW;
                     // A length of zero ends the fetch only when the address wraps to zero.
                     if (s.addr + 24'h000001 == {8'h00, s.imageLen}) begin
                        irqSet[`IRQ_LOAD_BIT] = 1'b1;
                        if (s.kindInternal) begin
                           next_s.internalRom = 1'b1; // [R7] [R8]
                        end
                        next_s.boot = BOOT_APP_START;
                     end
                  end
                  default: next_s.phase = PH_ADDR_LOW;
               endcase
            end
         end

         BOOT_APP_WAIT: begin
            // A host-loaded image starts once its reply is acknowledged.
            if (ackPulse) begin
               next_s.boot = BOOT_APP_START;
            end
         end

         BOOT_APP_START: begin
            // The mismatch check runs for both loading methods. [R13]
            if (imageCompatible) begin
               next_s.appRunning = 1'b1;
            end else begin
               next_s.appFailed      = 1'b1; // [R9]
               next_s.reply          = `MSG_APP_FAILURE; // [R12]
               next_s.irqPinActive   = 1'b1; // [R11]
               irqSet[`IRQ_FAIL_BIT] = 1'b1;
            end
            next_s.boot = BOOT_RUN;
         end

         // Only a new reset leaves the final states.
         BOOT_RUN:  next_s.boot = BOOT_RUN;
         BOOT_HALT: next_s.boot = BOOT_HALT;
         default:   next_s.boot = BOOT_IDLE;
      endcase

      // A new event wins over a clear in the same cycle.
      next_s.irqStatus = (s.irqStatus & ~irqClr) | irqSet;
   end

   // The whole state moves on every edge; reset loads the constant image.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   // Bus answers.
   assign prdata  = s.prdata;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !isMapped(paddr);
   assign irq     = |(s.irqStatus & s.irqMask);

   // The shared pin is only pulled low, never driven high; the host masks
   // it while code loads, so no request is raised during a fetch. [R15]
   assign hostInterruptRequestNOut = 1'b0;
   assign hostInterruptRequestNOe  = s.irqPinActive;

   // Memory port and status outputs.
   assign extMemOutputStrobeN = s.strobeN;
   assign extMemSelectN       = s.selectN;
   assign extMemAddrDataOut   = s.adOut;
   assign extMemAddrDataOe    = s.adOe;
   assign fetchValid          = s.fetchValid;
   assign fetchByte           = s.fetchByte;
   assign divFactor           = s.divFactor;
   assign pllLocked           = s.pllLocked;
   assign internalRomEnable   = s.internalRom;
   assign appRunning          = s.appRunning;

endmodule : fast_autoboot_loader

// *** include/boot_loader_map.svh ***
`ifndef BOOT_LOADER_MAP_SVH
`define BOOT_LOADER_MAP_SVH
// Behaviour
// (R1) A host starts fast autoboot by a serial loader download, select high.
// (R2) After a fast loader the core clock speeds up, then memory is fetched.
// (R3) Plain autoboot divides by twelve; fast loaders use eight, six or four.
// (R4) Fast loaders leave the loop unlocked, so fetches follow the oscillator.
// (R5) The loop locks only on the lock command, often sent with decode start.
// (R6) The chosen divide factor keeps fetches within memory and latch timing.
// (R7) The internal-boot loader may come by host download or by autoboot.
// (R8) After the internal-boot loader, on-chip ROM code runs with no download.
// (R9) A foreign image may get the success byte yet fail to initialise.
// (R10) The host waits at least five milliseconds before any configuration.
// (R11) With the request line low after a download, the host reads the byte; the loader pulls the line low only for the 0xF0 failure byte.
// (R12) A mismatched application makes that read return 0xF0.
// (R13) The failure report follows both host download and autoboot.
// (R14) Three strobe rises latch address bytes; the fourth low pulse reads ROM.
// (R15) While code loads from memory the host masks the request line.
// (R16) The new divide factor applies before the first address byte latches.

// Register byte offsets on the APB bus.
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_REPLY       8'h08
`define REG_IRQ_STATUS  8'h0c
`define REG_IRQ_MASK    8'h10
`define REG_IMAGE_LEN   8'h14

// Control register fields.
`define CTRL_LOCK_BIT      0
`define CTRL_ACK_BIT       1
`define CTRL_KIND_BIT      2

// Interrupt status fields.
`define IRQ_LOAD_BIT       0
`define IRQ_FAIL_BIT       1
`define IRQ_LOCK_BIT       2
`define IRQ_WIDTH          3

// Divide factors of the core clock.
`define DIV_STANDARD       4'hc
`define DIV_FAST8          4'h8
`define DIV_FAST6          4'h6
`define DIV_FAST4          4'h4

// Reply bytes, reset values, last address byte index and strap settle count.
`define MSG_DOWNLOAD_OK    8'h02
`define MSG_BAD_CHECKSUM   8'hff
`define MSG_APP_FAILURE    8'hf0
`define IMAGE_LEN_RESET    16'h6000
`define ADDR_LAST_INDEX    2'h2
`define STRAP_SETTLE       2'h2
`endif

// *** include/boot_loader_pkg.sv ***
package boot_loader_pkg;

   // Loader image kinds delivered by the serial download path.
   typedef enum logic [2:0] {
      LOAD_APP,
      LOAD_FAST8,
      LOAD_FAST6,
      LOAD_FAST4,
      LOAD_INTERNAL
   } load_kind_type;

   // Top-level boot sequence.
   typedef enum logic [2:0] {
      BOOT_IDLE,
      BOOT_SETTLE,
      BOOT_FETCH,
      BOOT_APP_WAIT,
      BOOT_APP_START,
      BOOT_RUN,
      BOOT_HALT
   } boot_state_type;

   // Phases of one external memory byte fetch.
   typedef enum logic [1:0] {
      PH_ADDR_LOW,
      PH_ADDR_HIGH,
      PH_DATA_LOW,
      PH_DATA_HIGH
   } fetch_phase_type;

   // One finished serial download, as a single-cycle event.
   typedef struct packed {
      logic          done;
      load_kind_type kind;
      logic          checksumOk;
   } host_load_type;

   // Whole state of the loader.
   typedef struct packed {
      boot_state_type  boot;
      fetch_phase_type phase;
      logic [1:0]      addrIdx;
      logic [23:0]     addr;
      logic [3:0]      divFactor;
      logic            divLoad;
      logic            pllLocked;
      logic            internalRom;
      logic            appRunning;
      logic            appFailed;
      logic [7:0]      reply;
      logic            irqPinActive;
      logic [2:0]      irqStatus;
      logic [2:0]      irqMask;
      logic [15:0]     imageLen;
      logic            kindInternal;
      logic [31:0]     prdata;
      logic            strobeN;
      logic            selectN;
      logic [7:0]      adOut;
      logic            adOe;
      logic            fetchValid;
      logic [7:0]      fetchByte;
      logic [1:0]      strapCnt;
      logic            strapDone;
   } loader_state_type;

   // Core clock divider state.
   typedef struct packed {
      logic [3:0] count;
   } divider_state_type;

endpackage : boot_loader_pkg

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
`include "boot_loader_map.svh"

module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst,
   // Pins in and settled copies out.
   input  wire logic [WIDTH-1:0] pinIn,
   output      logic [WIDTH-1:0] pinOut
);
   import boot_loader_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_type;

   sync_state_type s;
   sync_state_type next_s;

   // Only the second stage is read, so metastability stays in the first.
   always_comb begin
      next_s.first  = pinIn;
      next_s.second = s.first;
   end

   // Both stages reset to the idle level of the pins.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{first: INIT, second: INIT};
      end else begin
         s <= next_s;
      end
   end

   assign pinOut = s.second;

endmodule : pin_sync

// *** rtl/core_clock_divider.sv ***
`timescale 1ns/1ps
`include "boot_loader_map.svh"

module core_clock_divider (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst,
   // Divide factor and restart.
   input  wire logic [3:0] factor,
   input  wire logic       restart,
   // One-cycle core tick.
   output      logic       tick
);
   import boot_loader_pkg::*;

   divider_state_type s;
   divider_state_type next_s;

   // A restart begins a fresh period, so no short tick follows a change.
   always_comb begin
      next_s = s;
      if (restart || tick) begin
         next_s.count = 4'h0;
      end else begin
         next_s.count = s.count + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{count: 4'h0};
      end else begin
         s <= next_s;
      end
   end

   assign tick = !restart && (s.count == factor - 4'h1);

endmodule : core_clock_divider

// *** test/boot_loader_properties.sv ***
`timescale 1ns/1ps
`include "boot_loader_map.svh"

module boot_loader_properties (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // Bus and pins under watch.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic        pslverr,
   input  wire logic        hostInterruptRequestNOe,
   input  wire logic        extMemOutputStrobeN,
   input  wire logic        extMemSelectN,
   input  wire logic        extMemAddrDataOe,
   input  wire logic        fetchValid,
   input  wire logic [3:0]  divFactor,
   input  wire logic        pllLocked
);
   logic [2:0] latchCnt;
   logic       strobeQ;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Counts address latch edges; a delayed copy avoids $rose here.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latchCnt <= 3'h0;
         strobeQ <= 1'b1;
      end else begin
         strobeQ <= extMemOutputStrobeN;
         if (fetchValid) begin
            latchCnt <= 3'h0;
         end else if (extMemOutputStrobeN && !strobeQ &&
                      extMemAddrDataOe) begin
            latchCnt <= latchCnt + 3'h1;
         end
      end
   end

   a_div_value: assert property ($changed(divFactor) |->
      divFactor inside {`DIV_FAST8, `DIV_FAST6, `DIV_FAST4})
      else $error("bad divide factor");
   a_div_steady: assert property (!extMemSelectN |->
      $stable(divFactor)) else $error("divide factor moved in a fetch");
   a_three_latches: assert property ($fell(extMemSelectN) |->
      latchCnt == 3'h3) else $error("wrong latch count");
   a_select_release: assert property (!extMemSelectN |->
      !extMemAddrDataOe && !extMemOutputStrobeN)
      else $error("bus driven while memory selected");
   a_fetch_pulse: assert property (fetchValid |->
      $rose(extMemSelectN) ##1 !fetchValid)
      else $error("stray byte valid");
   a_lock_cmd: assert property ($rose(pllLocked) |->
      $past(psel && penable && pwrite && paddr == `REG_CTRL
            && pwdata[`CTRL_LOCK_BIT]))
      else $error("loop locked without the lock command");
   a_pin_release: assert property ($fell(hostInterruptRequestNOe) |->
      $past(psel && penable && !pwrite && paddr == `REG_REPLY))
      else $error("pin freed without read");
   a_bad_addr: assert property (psel && penable && paddr > 8'h14 |->
      pslverr) else $error("unmapped access not refused");
endmodule : boot_loader_properties

bind fast_autoboot_loader boot_loader_properties u_props (
   .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
   .hostInterruptRequestNOe, .extMemOutputStrobeN, .extMemSelectN,
   .extMemAddrDataOe, .fetchValid, .divFactor, .pllLocked);

// *** test/boot_host_model.sv ***
`timescale 1ns/1ps

module boot_host_model (
   // Clock.
   input  wire logic                   clk,
   // Pin as the device drives it.
   input  wire logic                   pinOut,
   input  wire logic                   pinOe,
   // Pin level and download events.
   output      logic                   pinLevel,
   output      boot_loader_pkg::host_load_type hostLoad
);
   import boot_loader_pkg::*;
   logic holdLow = 1'b0;

   // Open drain with pull-up: low while either party pulls it.
   assign pinLevel = !holdLow && (pinOe ? pinOut : 1'b1);

   initial hostLoad = '0;

   // Drives the select line around reset; never looks at it in a load.
   task automatic strap(input logic low);
      holdLow <= low;
   endtask : strap

   // A finished serial download, select line left high.
   task automatic download(input load_kind_type k, input logic ok);
      @(posedge clk);
      holdLow <= 1'b0;
      hostLoad <= '{1'b1, k, ok};
      @(posedge clk);
      hostLoad <= '0;
   endtask : download
endmodule : boot_host_model

// *** test/fast_autoboot_loader_tb_top.sv ***
`timescale 1ns/1ps
`include "boot_loader_map.svh"

module fast_autoboot_loader_tb_top;
   import boot_loader_pkg::*;
   logic          clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic          pinOut, pinOe, pinLevel, stb, sel, adOe, fValid, err;
   logic          compat, pll, romEn, appRun;
   logic [7:0]    paddr, adIn, adOut, fByte;
   logic [31:0]   pwdata, prdata, q;
   logic [3:0]    div;
   logic [23:0]   lat;
   host_load_type hostLoad;
   int            errorCnt, testsRun;
   logic [7:0]    expQ[$];

   fast_autoboot_loader u_dut (.clk, .rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
      .hostInterruptRequestNIn(pinLevel), .hostInterruptRequestNOut(pinOut),
      .hostInterruptRequestNOe(pinOe), .hostLoad, .imageCompatible(compat),
      .extMemOutputStrobeN(stb), .extMemSelectN(sel),
      .extMemAddrDataIn(adIn), .extMemAddrDataOut(adOut),
      .extMemAddrDataOe(adOe), .fetchValid(fValid), .fetchByte(fByte),
      .divFactor(div), .pllLocked(pll), .internalRomEnable(romEn),
      .appRunning(appRun));
   boot_host_model u_host (.clk, .pinOut, .pinOe, .pinLevel, .hostLoad);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Latched address picks the ROM byte; released bus shows its inverse.
   always @(posedge stb) if (adOe) lat <= {lat[15:0], adOut};
   assign adIn = (!sel && !stb) ? (lat[7:0] ^ lat[15:8] ^ 8'h5a)
                                : ~(lat[7:0] ^ lat[15:8] ^ 8'h5a);

   task automatic chk(input string n, input logic [31:0] e, s);
      testsRun++;
      if (s !== e) begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // One transfer; request held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic stopTest;
      $display("mismatches %0d checks %0d", errorCnt, testsRun);
      if (errorCnt == 0 && testsRun > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stopTest

   // One boot from reset: host download, or strap autoboot when ab is set.
   task automatic run(input load_kind_type k, input logic ok, ab, cp);
      int n, d, t;
      n = 2 + $urandom % 3;
      d = k == LOAD_FAST8 ? 8 : k == LOAD_FAST6 ? 6 :
          k == LOAD_FAST4 ? 4 : 12;
      @(posedge clk);
      compat <= cp;
      rst <= 1'b1;
      u_host.strap(ab);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      apb(0, `REG_IMAGE_LEN, 0);
      chk("length reset", `IMAGE_LEN_RESET, q);
      apb(0, 8'h18, 0);
      chk("unmapped", 32'h80000000, {err, q[30:0]});
      apb(1, `REG_IMAGE_LEN, n);
      apb(1, `REG_IRQ_MASK, 7);
      apb(1, `REG_CTRL, {k == LOAD_INTERNAL, 2'b00});
      u_host.strap(1'b0);
      chk("divide reset", `DIV_STANDARD, div);
      if (!ab) u_host.download(k, ok);
      @(negedge clk);
      chk("divide", d, div);
      if (!ab) begin
         apb(0, `REG_REPLY, 0);
         chk("reply", ok ? `MSG_DOWNLOAD_OK : `MSG_BAD_CHECKSUM, q);
      end
      if (!ok) return;
      if (!ab && d == 12) apb(1, `REG_CTRL, {k == LOAD_INTERNAL, 2'b10});
      for (int i = 0; i < n && (ab || d < 12); i++)
         expQ.push_back(i[7:0] ^ i[15:8] ^ 8'h5a);
      for (int i = 0; expQ.size() > 0; i++) begin
         t = 0;
         do begin
            @(negedge clk);
            t++;
         end while (fValid !== 1'b1 && t < 5000);
         if (i > 0) chk("byte gap", 8 * d, t);
         chk("byte", expQ.pop_front(), fByte);
         chk("unlocked", 0, pll);
      end
      repeat (4) @(negedge clk);
      chk("running", cp, appRun);
      chk("rom enable", k == LOAD_INTERNAL, romEn);
      chk("pin", cp, pinLevel);
      chk("irq", 1, irq);
      if (!cp) begin
         apb(0, `REG_REPLY, 0);
         chk("failure", `MSG_APP_FAILURE, q);
         @(negedge clk);
         chk("pin free", 1, pinLevel);
      end
      apb(1, `REG_IRQ_STATUS, 7);
      @(negedge clk);
      chk("irq clear", 0, irq);
      apb(1, `REG_CTRL, 1);
      @(negedge clk);
      chk("locked", {2'b11}, {pll, irq});
   endtask : run

   initial begin
      {psel, penable, pwrite, paddr, pwdata, compat} = '0;
      rst = 1'b1;
      void'($urandom(5532));
      run(LOAD_FAST8, 1, 0, 1);
      run(LOAD_FAST6, 1, 0, 0);
      run(LOAD_FAST4, 1, 0, 1);
      run(LOAD_APP, 1, 0, 0);
      run(LOAD_INTERNAL, 1, 0, 1);
      run(LOAD_APP, 0, 0, 1);
      run(LOAD_INTERNAL, 1, 1, 1);
      run(LOAD_APP, 1, 1, 0);
      stopTest();
   end

   // A stuck wait ends the run as a mismatch.
   initial begin
      repeat (60000) @(posedge clk);
      errorCnt++;
      stopTest();
   end
endmodule : fast_autoboot_loader_tb_top
